// File: logic/osc_bank_params.svh
// constants of the oscillator indirect register bank
`ifndef OSC_BANK_PARAMS_SVH
`define OSC_BANK_PARAMS_SVH

// serial frame layout: read flag, 7-bit address, 24-bit data, msb first
`define OSC_FRAME_BITS 6'h20
`define OSC_FRAME_CNT_W 6
`define OSC_FRAME_ADDR_W 7
`define OSC_FRAME_DATA_W 24
`define OSC_FRAME_CNT_MAX 6'h3F

// synthesizer register that carries the indirect oscillator word
`define OSC_INDIRECT_ADDR 7'h05

// indirect word fields
`define OSC_ID_MSB 2
`define OSC_ID_LSB 0
`define OSC_ADDR_MSB 6
`define OSC_ADDR_LSB 3
`define OSC_DATA_MSB 15
`define OSC_DATA_LSB 7
`define OSC_TARGET_ID 3'h0

// oscillator register addresses
`define OSC_REG_TUNING 4'h0
`define OSC_REG_POWER 4'h1
`define OSC_REG_DIVIDER 4'h2
`define OSC_REG_COUNT 3

// reset values (tuning holds subband 16 in bits 8:1)
`define OSC_TUNING_RESET 9'h020
`define OSC_POWER_RESET 9'h000
`define OSC_DIVIDER_RESET 9'h000
`define OSC_SUBBAND_RESET 8'h10
`define OSC_MAIN_DBM_BASE 3'h2
`define OSC_DIV_DBM_RESET 4'hC
// pin idle levels {select_n, data, clock}
`define OSC_PIN_IDLE 3'h4

// reserved fields that the host keeps at zero
`define OSC_POWER_RSVD_MASK 9'h080
`define OSC_DIVIDER_RSVD_MASK 9'h1F0

// special codes
`define OSC_BIAS_LOW_CURRENT 3'h0
`define OSC_BIAS_HIGH_PERF 3'h7
`define OSC_DIV_BYPASS 3'h7

`endif

// File: logic/osc_bank_pkg.sv
// types of the oscillator indirect register bank
package osc_bank_pkg;

  typedef struct packed {
    logic rnw;
    logic [6:0] addr;
    logic [23:0] data;
  } spi_frame_s;

  typedef struct packed {
    logic [7:0] unused;
    logic [8:0] data;
    logic [3:0] reg_addr;
    logic [2:0] id;
  } indirect_word_s;

  typedef struct packed {
    logic tune_source_select;
    logic [7:0] subband_select;
    logic [1:0] main_output_level;
    logic [2:0] oscillator_bias_level;
    logic [1:0] divided_output_level;
    logic divider_enable;
    logic [2:0] output_division_code;
    logic oscillator_powerdown;
  } osc_config_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_COMMIT = 2'b10
  } frame_state_e;

  typedef logic [8:0] osc_word_t;

endpackage

// File: logic/osc_reg_store.sv
// storage of the three write-only oscillator registers
`timescale 1ns/1ps
`include "osc_bank_params.svh"

module osc_reg_store
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire osc_bank_pkg::osc_word_t wr_data,
  // registered contents
  output osc_bank_pkg::osc_word_t words [`OSC_REG_COUNT]
);
  import osc_bank_pkg::*;

  localparam osc_word_t RESET_WORDS [`OSC_REG_COUNT] =
    '{`OSC_TUNING_RESET, `OSC_POWER_RESET, `OSC_DIVIDER_RESET};

  genvar i;
  generate
    for (i = 0; i < `OSC_REG_COUNT; i++)
    begin : g_entry
      // an address outside the bank selects no entry
      wire sel = wr_en && (wr_addr == 4'(i));
      always_ff @(posedge clk)
      begin
        if (rst)
          words[i] <= RESET_WORDS[i];
        else if (sel)
          words[i] <= wr_data;
      end
    end
  endgenerate

endmodule

// File: logic/osc_indirect_bank.sv
// oscillator indirect register bank behind the three-wire serial port
// Function
// - oscillator registers reached only through register 0x05
// - word bits 2:0 select subsystem, 000b oscillator
// - word bits 6:3 address the oscillator register
// - word bits 15:7 are data bits 8:0
// - tuning bit 0 picks internal or pin tune
// - tuning bits 8:1 subband, default 16
// - power bits 1:0 main level 2..5 dBm
// - power bits 4:2 bias, 0 low, 7 high
// - power bits 6:5 divided output level
// - power bit 8 enables divider and buffer
// - division ratio applies only while divider enabled
// - divider bits 2:0 ratio, 7 bypasses divider
// - divider bit 3 powers oscillator down
// - registers are write-only, no readback
`timescale 1ns/1ps
`include "osc_bank_params.svh"

module osc_indirect_bank
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // three-wire serial port
  input wire logic SPI_CLK,
  input wire logic SPI_DATA,
  input wire logic SPI_SEL_N,
  // oscillator settings
  output osc_bank_pkg::osc_config_s OSC_CONFIG,
  // decoded controls
  output logic PRIMARY_OUTPUT_ENABLE,
  output logic DIVIDED_OUTPUT_ENABLE,
  output logic [2:0] DIVIDE_LOG2,
  output logic [2:0] MAIN_OUTPUT_DBM,
  output logic signed [3:0] DIVIDED_OUTPUT_DBM,
  output logic BIAS_HIGH_PERF,
  output logic BIAS_LOW_CURRENT,
  // write events
  output logic WRITE_DONE,
  output logic WRITE_IGNORED,
  output logic RESERVED_WRITE,
  output logic FRAME_ERROR
);
  import osc_bank_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the third stage only feeds edge detection
  // reset at the idle pin levels so release shows no false edge

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pin_meta <= `OSC_PIN_IDLE;
      pin_sync <= `OSC_PIN_IDLE;
      pin_last <= `OSC_PIN_IDLE;
    end
    else
    begin
      pin_meta <= {SPI_SEL_N, SPI_DATA, SPI_CLK};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  wire sclk_rise = pin_sync[0] && !pin_last[0];
  wire sdi_bit = pin_sync[1];
  wire sel_active = !pin_sync[2];
  wire sel_fall = !pin_sync[2] && pin_last[2];
  wire sel_rise = pin_sync[2] && !pin_last[2];

  ////////////////////////////////////////////////////////////////////////////
  // frame capture

  frame_state_e state;
  frame_state_e next_state;
  logic [31:0] shift;
  logic [`OSC_FRAME_CNT_W-1:0] bit_count;
  spi_frame_s frame;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (sel_fall)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (sel_rise)
          next_state = ST_COMMIT;
      ST_COMMIT:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // bits beyond the frame length roll out and mark the frame bad;
  // the count sticks at its top so a long frame cannot wrap back to 32
  wire count_full = (bit_count == `OSC_FRAME_BITS);
  wire count_top = (bit_count == `OSC_FRAME_CNT_MAX);
  wire [`OSC_FRAME_CNT_W-1:0] next_bit_count = count_top ? bit_count : bit_count + 6'h01;
  wire take_bit = (state == ST_SHIFT) && sel_active && sclk_rise;
  // a frame is judged once, in the single commit cycle after select rises
  wire frame_end = (state == ST_SHIFT) && sel_rise;
  wire in_commit = (state == ST_COMMIT);

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      shift <= 32'h0000_0000;
      bit_count <= '0;
    end
    else if (sel_fall)
    begin
      shift <= 32'h0000_0000;
      bit_count <= '0;
    end
    else if (take_bit)
    begin
      shift <= {shift[30:0], sdi_bit};
      bit_count <= next_bit_count;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      frame <= '0;
    else if (frame_end)
      frame <= shift;
  end

  logic frame_len_ok;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      frame_len_ok <= 1'b0;
    else if (frame_end)
      frame_len_ok <= count_full;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect decode

  indirect_word_s word;
  assign word = frame.data;

  // reads fall through here: the bank has no readback path
  wire is_commit = in_commit && frame_len_ok && !frame.rnw;
  wire hits_indirect = is_commit && (frame.addr == `OSC_INDIRECT_ADDR);
  wire id_match = (word.id == `OSC_TARGET_ID);
  wire store_write = hits_indirect && id_match;
  wire [3:0] store_addr = word.reg_addr;
  osc_word_t store_data;
  assign store_data = word.data;

  // host keeps reserved bits at zero; a breach is flagged, not blocked
  wire power_rsvd = (store_addr == `OSC_REG_POWER) &&
    ((store_data & `OSC_POWER_RSVD_MASK) != 9'h000);
  wire divider_rsvd = (store_addr == `OSC_REG_DIVIDER) &&
    ((store_data & `OSC_DIVIDER_RSVD_MASK) != 9'h000);

  osc_word_t words [`OSC_REG_COUNT];

  // addresses 3 and up pulse the done flag but land in no entry
  osc_reg_store u_store
  (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_en(store_write),
    .wr_addr(store_addr),
    .wr_data(store_data),
    .words(words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // field extraction

  osc_word_t tuning;
  osc_word_t power;
  osc_word_t divider;
  assign tuning = words[0];
  assign power = words[1];
  assign divider = words[2];

  wire tune_src = tuning[0];
  wire [7:0] subband = tuning[8:1];
  wire [1:0] main_level = power[1:0];
  wire [2:0] bias_level = power[4:2];
  wire [1:0] div_level = power[6:5];
  wire div_enable = power[8];
  wire [2:0] div_code = divider[2:0];
  wire osc_pd = divider[3];

  // named next values keep the output registers plain copies
  wire next_primary_en = !osc_pd;
  wire next_divided_en = div_enable && !osc_pd;
  wire next_bias_high = (bias_level == `OSC_BIAS_HIGH_PERF);
  wire next_bias_low = (bias_level == `OSC_BIAS_LOW_CURRENT);

  // code 0 divides by 128, each step halves, 7 is bypass
  wire [2:0] next_log2 = div_enable ? (3'h7 - div_code) : 3'h0;
  wire [2:0] next_main_dbm = 3'(main_level) + `OSC_MAIN_DBM_BASE;
  logic signed [3:0] next_div_dbm;

  always_comb
  begin
    // codes 1 and 2 give the same level
    case (div_level)
      2'h0: next_div_dbm = -4'sh4;
      2'h1: next_div_dbm = 4'sh0;
      2'h2: next_div_dbm = 4'sh0;
      2'h3: next_div_dbm = 4'sh3;
      default: next_div_dbm = 4'sh0;
    endcase
  end

  osc_config_s next_config;
  assign next_config = '{
    tune_source_select: tune_src,
    subband_select: subband,
    main_output_level: main_level,
    oscillator_bias_level: bias_level,
    divided_output_level: div_level,
    divider_enable: div_enable,
    output_division_code: div_code,
    oscillator_powerdown: osc_pd
  };

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  // reset values equal what the reset words decode to

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      OSC_CONFIG <= '{subband_select: `OSC_SUBBAND_RESET, default: '0};
      PRIMARY_OUTPUT_ENABLE <= 1'b1;
      DIVIDED_OUTPUT_ENABLE <= 1'b0;
      DIVIDE_LOG2 <= 3'h0;
      MAIN_OUTPUT_DBM <= `OSC_MAIN_DBM_BASE;
      DIVIDED_OUTPUT_DBM <= `OSC_DIV_DBM_RESET;
      BIAS_HIGH_PERF <= 1'b0;
      BIAS_LOW_CURRENT <= 1'b1;
    end
    else
    begin
      OSC_CONFIG <= next_config;
      PRIMARY_OUTPUT_ENABLE <= next_primary_en;
      DIVIDED_OUTPUT_ENABLE <= next_divided_en;
      DIVIDE_LOG2 <= next_log2;
      MAIN_OUTPUT_DBM <= next_main_dbm;
      DIVIDED_OUTPUT_DBM <= next_div_dbm;
      BIAS_HIGH_PERF <= next_bias_high;
      BIAS_LOW_CURRENT <= next_bias_low;
    end
  end

  // pulse sources, all decided in the commit cycle
  wire next_ignored = hits_indirect && !id_match;
  wire next_reserved = store_write && (power_rsvd || divider_rsvd);
  wire next_frame_error = in_commit && !frame_len_ok;

  // one-cycle event pulses, aligned with the store update
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      WRITE_DONE <= 1'b0;
      WRITE_IGNORED <= 1'b0;
      RESERVED_WRITE <= 1'b0;
      FRAME_ERROR <= 1'b0;
    end
    else
    begin
      WRITE_DONE <= store_write;
      WRITE_IGNORED <= next_ignored;
      RESERVED_WRITE <= next_reserved;
      FRAME_ERROR <= next_frame_error;
    end
  end

endmodule

// File: verification/osc_bank_sva.sv
// port assertions of the oscillator register bank
`timescale 1ns/1ps
module osc_bank_sva
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // serial port
  input wire logic SPI_CLK,
  input wire logic SPI_DATA,
  input wire logic SPI_SEL_N,
  // settings and decodes
  input wire osc_bank_pkg::osc_config_s OSC_CONFIG,
  input wire logic PRIMARY_OUTPUT_ENABLE,
  input wire logic DIVIDED_OUTPUT_ENABLE,
  input wire logic [2:0] DIVIDE_LOG2,
  input wire logic [2:0] MAIN_OUTPUT_DBM,
  input wire logic signed [3:0] DIVIDED_OUTPUT_DBM,
  input wire logic BIAS_HIGH_PERF,
  input wire logic BIAS_LOW_CURRENT,
  // events
  input wire logic WRITE_DONE,
  input wire logic WRITE_IGNORED,
  input wire logic RESERVED_WRITE,
  input wire logic FRAME_ERROR
);
  import osc_bank_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  chk_main_level: assert property (MAIN_OUTPUT_DBM == OSC_CONFIG.main_output_level + 3'h2)
    else $error("main level wrong");
  chk_bias_modes: assert property ({BIAS_HIGH_PERF, BIAS_LOW_CURRENT} ==
    {OSC_CONFIG.oscillator_bias_level == 3'h7, OSC_CONFIG.oscillator_bias_level == 3'h0})
    else $error("bias flags wrong");
  chk_div_level: assert property (DIVIDED_OUTPUT_DBM ==
    ((OSC_CONFIG.divided_output_level == 2'h0) ? 4'hC :
    (OSC_CONFIG.divided_output_level == 2'h3) ? 4'h3 : 4'h0)) else $error("div level wrong");
  chk_div_enable: assert property (DIVIDED_OUTPUT_ENABLE ==
    (OSC_CONFIG.divider_enable && !OSC_CONFIG.oscillator_powerdown)) else $error("div enable");
  chk_ratio_gate: assert property (DIVIDE_LOG2 == (OSC_CONFIG.divider_enable ?
    3'h7 - OSC_CONFIG.output_division_code : 3'h0)) else $error("ratio wrong");
  chk_power_down: assert property (PRIMARY_OUTPUT_ENABLE ==
    !OSC_CONFIG.oscillator_powerdown) else $error("powerdown wrong");
  chk_done_pulse: assert property (WRITE_DONE |=> !WRITE_DONE)
    else $error("done too long");
  chk_done_after: assert property ((WRITE_DONE || WRITE_IGNORED) |-> $past(SPI_SEL_N, 4))
    else $error("write before frame end");
  chk_config_hold: assert property ($changed(OSC_CONFIG) |-> $past(WRITE_DONE))
    else $error("config moved without write");
  cov_done: cover property (WRITE_DONE);
  cov_ignored: cover property (WRITE_IGNORED);
  cov_reserved: cover property (RESERVED_WRITE);
  cov_frame_err: cover property (FRAME_ERROR);
endmodule
bind osc_indirect_bank osc_bank_sva u_osc_bank_sva (.CLK_SYS, .RST, .SPI_CLK, .SPI_DATA,
  .SPI_SEL_N, .OSC_CONFIG, .PRIMARY_OUTPUT_ENABLE, .DIVIDED_OUTPUT_ENABLE, .DIVIDE_LOG2,
  .MAIN_OUTPUT_DBM, .DIVIDED_OUTPUT_DBM, .BIAS_HIGH_PERF, .BIAS_LOW_CURRENT, .WRITE_DONE,
  .WRITE_IGNORED, .RESERVED_WRITE, .FRAME_ERROR);

// File: verification/osc_host_model.sv
// host controller model on the three-wire serial port
`timescale 1ns/1ps
module osc_host_model
(
  // clock
  input wire logic clk,
  // serial port
  output logic sclk,
  output logic sdata,
  output logic sel_n
);
  // idle levels; called once by the bench so one process drives the pins
  task automatic idle();
    sclk = 1'b0;
    sdata = 1'b0;
    sel_n = 1'b1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // phases of 4 cycles keep the 3-cycle minimum with margin
  task automatic send(input logic [31:0] f, input int n);
    tick(1);
    sel_n = 1'b0;
    tick(4);
    for (int i = 31; i > 31 - n; i--)
    begin
      sdata = f[i];
      tick(4);
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    sel_n = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    sdata = ~sdata;
  endtask
endmodule

// File: verification/test_osc_indirect_bank.sv
// testbench of the oscillator indirect register bank
`timescale 1ns/1ps
module test_osc_indirect_bank;
  import osc_bank_pkg::*;
  logic clk_sys, rst, sclk, sdata, sel_n, prim, dive, bhp, blc, wdone, wign, wres, ferr;
  logic [2:0] dlog, mdbm;
  logic signed [3:0] ddbm;
  logic [3:0] seen;
  logic seen_clr;
  osc_config_s cfg, e;
  int err_count = 0;
  int num_checks = 0;
  osc_indirect_bank u_osc_indirect_bank (.CLK_SYS(clk_sys), .RST(rst), .SPI_CLK(sclk),
    .SPI_DATA(sdata), .SPI_SEL_N(sel_n), .OSC_CONFIG(cfg), .PRIMARY_OUTPUT_ENABLE(prim),
    .DIVIDED_OUTPUT_ENABLE(dive), .DIVIDE_LOG2(dlog), .MAIN_OUTPUT_DBM(mdbm),
    .DIVIDED_OUTPUT_DBM(ddbm), .BIAS_HIGH_PERF(bhp), .BIAS_LOW_CURRENT(blc),
    .WRITE_DONE(wdone), .WRITE_IGNORED(wign), .RESERVED_WRITE(wres), .FRAME_ERROR(ferr));
  osc_host_model u_osc_host_model (.clk(clk_sys), .sclk(sclk), .sdata(sdata), .sel_n(sel_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // one-cycle pulses collected: done, ignored, reserved, frame error
  always @(posedge clk_sys) seen <= seen_clr ? 4'h0 : (seen | {wdone, wign, wres, ferr});
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] w, input int n,
    input logic [3:0] fl);
    seen_clr = 1'b1;
    @(posedge clk_sys);
    #1;
    seen_clr = 1'b0;
    u_osc_host_model.send({hdr, 8'h00, w}, n);
    repeat (10) @(posedge clk_sys);
    #1;
    check(seen, fl);
  endtask
  task automatic wr(input logic [3:0] ra, input logic [8:0] d, input logic [3:0] fl);
    xfer(8'h05, {d, ra, 3'h0}, 32, fl);
  endtask
  task automatic expect_all();
    check(cfg, e);
    check(prim, !e.oscillator_powerdown);
    check(dive, e.divider_enable & !e.oscillator_powerdown);
    check(dlog, e.divider_enable ? 3'h7 - e.output_division_code : 3'h0);
    check(mdbm, e.main_output_level + 3'h2);
    check({ddbm}, (e.divided_output_level == 2'h0) ? 4'hC :
      (e.divided_output_level == 2'h3) ? 4'h3 : 4'h0);
    check({bhp, blc}, {e.oscillator_bias_level == 3'h7, e.oscillator_bias_level == 3'h0});
  endtask
  task automatic reset_dut(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    e = '0;
    e.subband_select = 8'h10;
    expect_all();
  endtask
  initial
  begin
    u_osc_host_model.idle();
    rst = 1'b1;
    seen_clr = 1'b1;
    reset_dut(20);
    // highest address first, subband last; reserved bits kept zero
    e.output_division_code = 3'h1;
    wr(4'h2, 9'h001, 4'h8);
    expect_all();
    {e.divider_enable, e.divided_output_level, e.oscillator_bias_level} = 6'h3F;
    e.main_output_level = 2'h3;
    wr(4'h1, 9'h17F, 4'h8);
    expect_all();
    e.subband_select = 8'hCD;
    wr(4'h0, 9'h19A, 4'h8);
    expect_all();
    for (int i = 0; i < 4; i++)
    begin
      e.main_output_level = i[1:0];
      e.divided_output_level = i[1:0];
      e.oscillator_bias_level = (i == 0) ? 3'h0 : 3'h7;
      wr(4'h1, {1'b1, 1'b0, i[1:0], e.oscillator_bias_level, i[1:0]}, 4'h8);
      expect_all();
    end
    for (int i = 0; i < 8; i++)
    begin
      e.output_division_code = i[2:0];
      wr(4'h2, {6'h00, i[2:0]}, 4'h8);
      expect_all();
    end
    e.oscillator_powerdown = 1'b1;
    wr(4'h2, 9'h00F, 4'h8);
    expect_all();
    e.tune_source_select = 1'b1;
    e.subband_select = 8'hFF;
    wr(4'h0, 9'h1FF, 4'h8);
    expect_all();
    // refused traffic leaves every setting alone
    xfer(8'h05, 16'h3F89, 32, 4'h4);
    xfer(8'h06, 16'h0090, 32, 4'h0);
    xfer(8'h85, 16'h0090, 32, 4'h0);
    xfer(8'h05, 16'h0090, 31, 4'h1);
    wr(4'h3, 9'h1FF, 4'h8);
    expect_all();
    {e.divider_enable, e.divided_output_level, e.oscillator_bias_level} = 6'h00;
    e.main_output_level = 2'h0;
    wr(4'h1, 9'h080, 4'hA);
    expect_all();
    reset_dut(3);
    end_sim();
  end
  initial
  begin
    #1000000;
    err_count++;
    end_sim();
  end
endmodule
